// ### hcc_pkg.sv
// package: offsets, bit positions and reset values for the host control flags
package hcc_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0]  OFS_SET          = 8'h50;
  localparam logic [7:0]  OFS_CLEAR        = 8'h54;
  // ------------------------------------------------------------
  // bit positions
  // ------------------------------------------------------------
  localparam int          BIT_IMAGE_VALID  = 31;
  localparam int          BIT_SWAP_SUPP    = 30;
  localparam int          BIT_LATE_ACK     = 29;
  localparam int          BIT_PHY_DELEG    = 23;
  localparam int          BIT_PHY_ENH      = 22;
  localparam int          BIT_LINK_PWR     = 19;
  localparam int          BIT_POST_WR      = 18;
  localparam int          BIT_LINK_ACTIVE  = 17;
  localparam int          BIT_SOFT_RESET   = 16;
  // ------------------------------------------------------------
  // masks and reset values
  // ------------------------------------------------------------
  // writable flags: 31, 30, 29, 22, 19, 18, 17 and the software reset bit 16
  localparam logic [31:0] RW_MASK          = 32'he04f0000;
  localparam logic [31:0] RESET_VALUE      = 32'h00000000;
  localparam logic        PHY_DELEG_DEFAULT = 1'b1;
  // ------------------------------------------------------------
  // acknowledge codes on the 1394 side
  // ------------------------------------------------------------
  localparam logic [3:0]  ACK_COMPLETE     = 4'h1;
  localparam logic [3:0]  ACK_PENDING      = 4'h2;
  localparam logic [3:0]  ACK_TARDY        = 4'hb;
  localparam logic [3:0]  ACK_TYPE_ERROR   = 4'he;
  // software reset count limit; the reset bit stays set for 9 clock cycles
  localparam logic [3:0]  SOFT_RESET_CYCLES = 4'h8;
endpackage : hcc_pkg

// ### hcc_control_flags.sv
// host controller control flags: set/clear register pair and its gating logic
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module hcc_control_flags (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  input  wire logic        eeprom_load,
  input  wire logic        eeprom_phy_deleg,
  input  wire logic        bib_fetch_error,
  input  wire logic        bus_reset,
  input  wire logic        rx_req,
  input  wire logic        rx_to_rom,
  input  wire logic        rx_block_read,
  output logic             ack_valid,
  output logic      [3:0]  ack_code,
  output logic             tardy_event,
  output logic             rom_update_en,
  output logic             byte_swap_en,
  output logic             link_connected,
  output logic             link_power_on,
  output logic             posted_write_en,
  output logic             phy_enh_use,
  output logic             fifo_flush
);

  // ------------------------------------------------------------
  // flag state
  // ------------------------------------------------------------
  logic [31:0] flags_reg;
  logic [31:0] flags_next;
  logic        deleg_reg;
  logic        deleg_next;
  logic [3:0]  srst_cnt_reg;
  logic [3:0]  srst_cnt_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] rd_value;
  logic        srst_active;

  assign srst_active = flags_reg[hcc_pkg::BIT_SOFT_RESET];

  // current read value with reserved bits forced to zero
  always_comb begin
    rd_value = flags_reg & hcc_pkg::RW_MASK;
    rd_value[hcc_pkg::BIT_PHY_DELEG] = deleg_reg;
  end

  // next flag values from writes, events and software reset
  always_comb begin
    flags_next    = flags_reg;
    srst_cnt_next = srst_cnt_reg;
    deleg_next    = deleg_reg;
    if (reg_write && reg_addr == hcc_pkg::OFS_SET) begin
      flags_next = flags_reg | (reg_wdata & hcc_pkg::RW_MASK);
    end else if (reg_write && reg_addr == hcc_pkg::OFS_CLEAR) begin
      flags_next = flags_reg & ~(reg_wdata & hcc_pkg::RW_MASK);
    end
    // relied upon: no gating of image valid set by link state here
    if (bib_fetch_error) begin
      flags_next[hcc_pkg::BIT_IMAGE_VALID] = 1'b0;
    end
    if (srst_active) begin
      if (srst_cnt_reg == hcc_pkg::SOFT_RESET_CYCLES) begin
        flags_next    = hcc_pkg::RESET_VALUE;
        srst_cnt_next = 4'h0;
      end else begin
        flags_next    = flags_reg;
        srst_cnt_next = srst_cnt_reg + 4'h1;
      end
    end
    if (eeprom_load) begin
      deleg_next = eeprom_phy_deleg;
    end
  end

  // flag registers
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_reg    <= hcc_pkg::RESET_VALUE;
      deleg_reg    <= hcc_pkg::PHY_DELEG_DEFAULT;
      srst_cnt_reg <= 4'h0;
    end else begin
      flags_reg    <= flags_next;
      deleg_reg    <= deleg_next;
      srst_cnt_reg <= srst_cnt_next;
    end
  end

  // ------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------
  // both addresses return flags; others read zero
  always_comb begin
    rdata_next = 32'h00000000;
    if (reg_read && (reg_addr == hcc_pkg::OFS_SET || reg_addr == hcc_pkg::OFS_CLEAR)) begin
      rdata_next = rd_value;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ------------------------------------------------------------
  // 1394 acknowledge path
  // ------------------------------------------------------------
  logic       ackv_reg;
  logic       ackv_next;
  logic [3:0] ackc_reg;
  logic [3:0] ackc_next;
  logic       tardy_reg;
  logic       tardy_next;

  // acknowledge selection for each request received while the link is active and no software reset runs
  always_comb begin
    ackv_next  = 1'b0;
    ackc_next  = hcc_pkg::ACK_COMPLETE;
    tardy_next = 1'b0;
    if (rx_req && flags_reg[hcc_pkg::BIT_LINK_ACTIVE] && !srst_active) begin
      ackv_next = 1'b1;
      if (rx_to_rom && rx_block_read && !flags_reg[hcc_pkg::BIT_IMAGE_VALID]) begin
        ackc_next = hcc_pkg::ACK_TYPE_ERROR;
      end else if (flags_reg[hcc_pkg::BIT_LATE_ACK]) begin
        ackc_next  = hcc_pkg::ACK_TARDY;
        tardy_next = 1'b1;
      end else if (rx_to_rom && rx_block_read) begin
        ackc_next = hcc_pkg::ACK_PENDING;
      end else begin
        ackc_next = hcc_pkg::ACK_COMPLETE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ackv_reg  <= 1'b0;
      ackc_reg  <= hcc_pkg::ACK_COMPLETE;
      tardy_reg <= 1'b0;
    end else begin
      ackv_reg  <= ackv_next;
      ackc_reg  <= ackc_next;
      tardy_reg <= tardy_next;
    end
  end

  assign ack_valid   = ackv_reg;
  assign ack_code    = ackc_reg;
  assign tardy_event = tardy_reg;

  // ------------------------------------------------------------
  // registered control outputs
  // ------------------------------------------------------------
  logic [6:0] ctl_reg;
  logic [6:0] ctl_next;

  always_comb begin
    ctl_next[0] = flags_next[hcc_pkg::BIT_IMAGE_VALID] & bus_reset;
    ctl_next[1] = ~flags_next[hcc_pkg::BIT_SWAP_SUPP];
    ctl_next[2] = flags_next[hcc_pkg::BIT_LINK_ACTIVE];
    ctl_next[3] = flags_next[hcc_pkg::BIT_LINK_PWR];
    ctl_next[4] = flags_next[hcc_pkg::BIT_POST_WR];
    ctl_next[5] = flags_next[hcc_pkg::BIT_PHY_ENH];
    ctl_next[6] = flags_next[hcc_pkg::BIT_SOFT_RESET];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_reg <= 7'h02;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  assign rom_update_en   = ctl_reg[0];
  assign byte_swap_en    = ctl_reg[1];
  assign link_connected  = ctl_reg[2];
  assign link_power_on   = ctl_reg[3];
  assign posted_write_en = ctl_reg[4];
  assign phy_enh_use     = ctl_reg[5];
  assign fifo_flush      = ctl_reg[6];

endmodule : hcc_control_flags

// ### hcc_control_flags_sva.sv
// checker: port assertions for the host control flags
`timescale 1ns/1ps
module hcc_control_flags_sva (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic        bus_reset,
  input wire logic        rx_req,
  input wire logic        ack_valid,
  input wire logic [3:0]  ack_code,
  input wire logic        tardy_event,
  input wire logic        rom_update_en,
  input wire logic        byte_swap_en,
  input wire logic        link_connected,
  input wire logic        fifo_flush
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // ----------------
  // port checks
  // ----------------
  idle_rdata_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("stray read data");
  resv_high_a: assert property (reg_rdata[28:24] == 5'h0) else $error("bits 28-24 set");
  resv_low_a: assert property (reg_rdata[15:0] == 16'h0) else $error("bits 15-0 set");
  swap_mirror_a: assert property (reg_read && reg_addr == hcc_pkg::OFS_SET
    |=> reg_rdata[30] != $past(byte_swap_en)) else $error("swap flag mismatch");
  link_gate_a: assert property (rx_req && !link_connected |=> !ack_valid)
    else $error("ack while link off");
  ack_given_a: assert property (rx_req && link_connected && !fifo_flush |=> ack_valid)
    else $error("missing ack");
  tardy_pair_a: assert property (tardy_event == (ack_valid && ack_code == hcc_pkg::ACK_TARDY))
    else $error("tardy event mismatch");
  rom_upd_a: assert property (rom_update_en |-> $past(bus_reset)) else $error("stray update");
  flush_len_a: assert property ($rose(fifo_flush) |-> fifo_flush[*8]) else $error("short");
  flush_end_a: assert property ($fell(fifo_flush) |-> !link_connected) else $error("link kept");
endmodule : hcc_control_flags_sva
bind hcc_control_flags hcc_control_flags_sva u_hcc_control_flags_sva (.*);

// ### hcc_node_model.sv
// model: remote bus node sending requests toward the flags block
`timescale 1ns/1ps
module hcc_node_model (
  input  wire logic clk,
  output logic      rx_req,
  output logic      rx_to_rom,
  output logic      rx_block_read
);
  initial begin
    rx_req = 1'b0;
    rx_to_rom = 1'b0;
    rx_block_read = 1'b0;
  end
  // one request cycle, qualifiers scrambled once idle
  task automatic send(input logic rom, input logic blk);
    @(posedge clk);
    rx_req <= 1'b1;
    rx_to_rom <= rom;
    rx_block_read <= blk;
    @(posedge clk);
    rx_req <= 1'b0;
    rx_to_rom <= ~rom;
    rx_block_read <= ~blk;
  endtask : send
endmodule : hcc_node_model

// ### hcc_control_flags_tb_top.sv
// testbench: register and bus traffic checked against a flag model
`timescale 1ns/1ps
module hcc_control_flags_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        eeprom_load = 1'b0;
  logic        eeprom_phy_deleg = 1'b1;
  logic        bib_fetch_error = 1'b0;
  logic        bus_reset = 1'b0;
  logic [31:0] reg_rdata, d;
  logic [3:0]  ack_code;
  logic        rx_req, rx_to_rom, rx_block_read, ack_valid, tardy_event, rom_update_en;
  logic        byte_swap_en, link_connected, link_power_on, posted_write_en, phy_enh_use;
  logic        fifo_flush;
  logic [31:0] m = 32'h00800000;
  logic [7:0]  ads [3] = '{hcc_pkg::OFS_SET, hcc_pkg::OFS_CLEAR, 8'h58};
  int          miscompares = 0;
  int          n_tests = 0;
  hcc_control_flags u_hcc_control_flags (.*);
  hcc_node_model u_hcc_node_model (.*);
  initial forever #2.5 clk = ~clk;
  // ----------------
  // bench tasks
  // ----------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // write one cycle, then update the flag model
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    if (a == ads[0]) m = m | (v & hcc_pkg::RW_MASK);
    if (a == ads[1]) m = m & ~(v & hcc_pkg::RW_MASK);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  task automatic brst(input logic exp);
    @(posedge clk);
    bus_reset <= 1'b1;
    @(posedge clk);
    bus_reset <= 1'b0;
    #1 chk({31'h0, rom_update_en}, {31'h0, exp});
  endtask : brst
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // hang guard
  initial begin
    #20000;
    miscompares++;
    report_and_stop();
  end
  // main sequence
  initial begin
    void'($urandom(32'hb985));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(ads[1], m);
    rd(ads[2], 32'h0);
    repeat (30) begin
      d = $urandom() & 32'h7fbeffff;
      wr(ads[$urandom_range(2)], d);
      rd(ads[0], m);
      chk({31'h0, byte_swap_en}, {31'h0, ~m[30]});
      chk({28'h0, phy_enh_use, link_power_on, posted_write_en, link_connected},
          {28'h0, m[22], m[19], m[18], m[17]});
    end
    // driver touches no enhancement while delegated reads zero
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      eeprom_phy_deleg <= v[0];
      eeprom_load <= 1'b1;
      @(posedge clk);
      eeprom_load <= 1'b0;
      m[23] = v[0];
      rd(ads[0], m);
    end
    wr(ads[1], 32'hffffffff);
    wr(ads[0], 32'h80000000);
    rd(ads[0], m);
    brst(1'b1);
    @(posedge clk);
    bib_fetch_error <= 1'b1;
    @(posedge clk);
    bib_fetch_error <= 1'b0;
    m[31] = 1'b0;
    rd(ads[0], m);
    brst(1'b0);
    u_hcc_node_model.send(1'b0, 1'b0);
    #1 chk({31'h0, ack_valid}, 32'h0);
    wr(ads[0], 32'h00420000);
    u_hcc_node_model.send(1'b1, 1'b1);
    #1 chk({27'h0, ack_valid, ack_code}, {27'h0, 1'b1, hcc_pkg::ACK_TYPE_ERROR});
    // tardy event starts clear, no power state change driven here
    wr(ads[0], 32'h20000000);
    u_hcc_node_model.send(1'b0, 1'b1);
    #1 chk({26'h0, ack_valid, tardy_event, ack_code}, {26'h0, 2'b11, hcc_pkg::ACK_TARDY});
    wr(ads[0], 32'h00010000);
    rd(ads[0], m | 32'h00010000);
    chk({31'h0, fifo_flush}, 32'h1);
    repeat (12) @(posedge clk);
    m = 32'h00800000;
    rd(ads[0], m);
    wr(ads[0], 32'h80080000);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    m = 32'h00800000;
    rd(ads[0], m);
    report_and_stop();
  end
endmodule : hcc_control_flags_tb_top
